// File: design/sere_pkg.sv
// shared constants and types for the serial eeprom read engine and its bus master
// assumes one 125 MHz core clock for both ends; the link clock is made by the master
package sere_pkg;
  // select code device types and memory geometry
  localparam logic [3:0]  ARRAY_TYPE  = 4'hA;
  localparam logic [3:0]  IDPG_TYPE   = 4'hB;
  localparam int          ARRAY_BYTES = 16384;
  localparam int          ID_BYTES    = 64;
  localparam logic [7:0]  ERASED      = 8'hFF;
  localparam logic [13:0] LAST_ADDR   = 14'h3FFF;
  localparam logic [7:0]  WAFER_LAST  = 8'h22;
  localparam logic [7:0]  PROBE_DATA  = 8'h00;

  // master register map and fields
  localparam logic [1:0]  REG_CMD     = 2'h0;
  localparam logic [1:0]  REG_ADDRESS = 2'h1;
  localparam logic [1:0]  REG_DATA    = 2'h2;
  localparam logic [1:0]  REG_STATUS  = 2'h3;
  localparam int          CMD_OP_LSB  = 0;
  localparam int          CMD_CS_LSB  = 2;
  localparam int          CMD_CNT_LSB = 8;
  localparam int          ST_BUSY     = 0;
  localparam int          ST_RXFULL   = 1;
  localparam int          ST_NACKERR  = 2;
  localparam int          ST_LOCKED   = 3;

  // link timing: 400 kHz bit time, four quarter steps per bit
  // a slower bit would make a full set of read runs too long to exercise
  localparam int          CLK_MHZ      = 125;
  localparam int          BIT_NS       = 2500;
  localparam int          QUARTER_CYC  = (CLK_MHZ * BIT_NS) / (4 * 1000);
  localparam logic [8:0]  QUARTER_LAST = 9'(QUARTER_CYC - 1);

  typedef enum logic [1:0] {
    OP_RANDOM,
    OP_CURRENT,
    OP_IDPAGE,
    OP_LOCKPROBE
  } sere_op_t;
endpackage

// File: design/sere_link_if.sv
// two-wire link between the bus master and the eeprom read engine
// both ends pull the data line low only; released means high
interface sere_link_if;
  logic scl;
  logic host_sda_out;
  logic host_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic sda;

  assign sda = (host_sda_oe_n | host_sda_out) & (dev_sda_oe_n | dev_sda_out);

  modport host (output scl, output host_sda_out, output host_sda_oe_n, input sda);
  modport dev  (input scl, input sda, output dev_sda_out, output dev_sda_oe_n);
endinterface

// File: design/sere_device.sv
// eeprom end: select decode, address load, random/current/sequential reads,
// identification page reads and the lock status probe
// assumes link levels synchronous to CORE_CLK and a clock much faster than the link
module sere_device #(
  parameter bit WAFER_FORM = 1'b0
) (
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  sere_link_if.dev         LINK,
  input  wire logic        WRITE_PROTECT_INPUT,
  input  wire logic        CHIP_SELECT_PIN_HIGH,
  input  wire logic        CHIP_SELECT_PIN_MID,
  input  wire logic        CHIP_SELECT_PIN_LOW,
  input  wire logic        ID_LOCKED,
  input  wire logic        WR_EN,
  input  wire logic        WR_ID_PAGE,
  input  wire logic [13:0] WR_ADDR,
  input  wire logic [7:0]  WR_DATA,
  output logic      [13:0] ADDR_COUNTER,
  output logic             SELECTED
);

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_SEL,
    ST_SEL_ACK,
    ST_ADR_HI,
    ST_HI_ACK,
    ST_ADR_LO,
    ST_LO_ACK,
    ST_WDATA,
    ST_WD_ACK,
    ST_RDATA,
    ST_RD_ACK,
    ST_WAIT
  } sere_dev_state_t;

  sere_dev_state_t state;
  logic [2:0]      bit_cnt;
  logic [7:0]      sh;
  logic [1:0]      ack_ph;
  logic            ack_ok;
  logic            id_sel;
  logic            rd_dir;
  logic [5:0]      addr_hi;
  logic [13:0]     addr_cnt;
  logic            sda_oe_n;
  logic            last_fresh;
  logic            scl_q;
  logic            sda_q;

  // memory contents belong to the write side; the power-up image is all ones
  logic [7:0] array_mem [sere_pkg::ARRAY_BYTES] = '{default: sere_pkg::ERASED};
  logic [7:0] id_mem    [sere_pkg::ID_BYTES]    = '{default: sere_pkg::ERASED};

  ////////////////////////////////////////////////////////////////////////////////
  // write side port and link sampling

  always_ff @(posedge CORE_CLK) begin
    if (WR_EN) begin
      if (WR_ID_PAGE) begin
        id_mem[WR_ADDR[5:0]] <= WR_DATA;
      end else begin
        array_mem[WR_ADDR] <= WR_DATA;
      end
    end
  end

  // wafer image: the last byte reads as the fixed pattern until first written
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      last_fresh <= WAFER_FORM;
    end else if (WR_EN && !WR_ID_PAGE && WR_ADDR == sere_pkg::LAST_ADDR) begin
      last_fresh <= 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= LINK.scl;
      sda_q <= LINK.sda;
    end
  end

  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;
  logic [7:0] in_byte;
  logic [7:0] rd_byte;
  logic       sel_hit;
  logic       byte_done;
  logic       cnt_load;
  logic       cnt_inc;

  always_comb begin
    scl_rise   = LINK.scl & ~scl_q;
    scl_fall   = ~LINK.scl & scl_q;
    start_cond = scl_q & LINK.scl & sda_q & ~LINK.sda;
    stop_cond  = scl_q & LINK.scl & ~sda_q & LINK.sda;
    in_byte    = {sh[6:0], LINK.sda};
    byte_done  = scl_rise && bit_cnt == 3'h7;
    sel_hit    = (in_byte[7:4] == sere_pkg::ARRAY_TYPE || in_byte[7:4] == sere_pkg::IDPG_TYPE)
                 && in_byte[3:1] == {CHIP_SELECT_PIN_HIGH, CHIP_SELECT_PIN_MID,
                                     CHIP_SELECT_PIN_LOW};
    cnt_load   = byte_done && state == ST_ADR_LO;
    cnt_inc    = scl_rise && state == ST_RD_ACK;
    if (id_sel) begin
      rd_byte = id_mem[addr_cnt[5:0]];
    end else if (last_fresh && addr_cnt == sere_pkg::LAST_ADDR) begin
      rd_byte = sere_pkg::WAFER_LAST;
    end else begin
      rd_byte = array_mem[addr_cnt];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // shared address counter

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      addr_cnt <= '0;
    end else if (cnt_load) begin
      if (id_sel) begin
        addr_cnt <= {8'h00, in_byte[5:0]};
      end else begin
        addr_cnt <= {addr_hi, in_byte};
      end
    end else if (cnt_inc) begin
      addr_cnt <= addr_cnt + 14'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // protocol sequencer: bits sampled on scl rise, data line changed on scl fall

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      state    <= ST_IDLE;
      bit_cnt  <= 3'h0;
      sh       <= 8'h00;
      ack_ph   <= 2'h0;
      ack_ok   <= 1'b0;
      id_sel   <= 1'b0;
      rd_dir   <= 1'b0;
      addr_hi  <= 6'h00;
      sda_oe_n <= 1'b1;
    end else if (start_cond) begin
      state    <= ST_SEL;
      bit_cnt  <= 3'h0;
      sda_oe_n <= 1'b1;
    end else if (stop_cond) begin
      state    <= ST_IDLE;
      sda_oe_n <= 1'b1;
    end else if (scl_rise) begin
      unique case (state)
        ST_SEL, ST_ADR_HI, ST_ADR_LO, ST_WDATA: begin
          sh      <= in_byte;
          bit_cnt <= bit_cnt + 3'h1;
          ack_ph  <= 2'h0;
          ack_ok  <= 1'b1;
          if (bit_cnt == 3'h7) begin
            unique case (state)
              ST_SEL: begin
                state  <= sel_hit ? ST_SEL_ACK : ST_IDLE;
                id_sel <= in_byte[7:4] == sere_pkg::IDPG_TYPE;
                rd_dir <= in_byte[0];
              end
              ST_ADR_HI: begin
                state   <= ST_HI_ACK;
                addr_hi <= in_byte[5:0];
              end
              ST_ADR_LO: state <= ST_LO_ACK;
              default: begin
                state  <= ST_WD_ACK;
                // wp only gates array data acks; reads never look at it
                ack_ok <= id_sel ? ~ID_LOCKED : ~WRITE_PROTECT_INPUT;
              end
            endcase
          end
        end
        ST_SEL_ACK, ST_HI_ACK, ST_LO_ACK, ST_WD_ACK: begin
          if (ack_ph == 2'h1) begin
            ack_ph <= 2'h2;
          end
        end
        ST_RDATA: begin
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == 3'h7) begin
            state <= ST_RD_ACK;
          end
        end
        ST_RD_ACK: begin
          state <= LINK.sda ? ST_IDLE : ST_RDATA;
        end
        ST_IDLE, ST_WAIT: ;
      endcase
    end else if (scl_fall) begin
      unique case (state)
        ST_SEL_ACK, ST_HI_ACK, ST_LO_ACK, ST_WD_ACK: begin
          if (ack_ph == 2'h0) begin
            sda_oe_n <= ~ack_ok;
            ack_ph   <= 2'h1;
          end else if (ack_ph == 2'h2) begin
            sda_oe_n <= 1'b1;
            bit_cnt  <= 3'h0;
            unique case (state)
              ST_SEL_ACK: begin
                if (rd_dir) begin
                  state    <= ST_RDATA;
                  sda_oe_n <= rd_byte[7];
                  sh       <= {rd_byte[6:0], 1'b0};
                end else begin
                  state <= ST_ADR_HI;
                end
              end
              ST_HI_ACK: state <= ST_ADR_LO;
              ST_LO_ACK: state <= ST_WDATA;
              default:   state <= ST_WAIT;
            endcase
          end
        end
        ST_RDATA: begin
          if (bit_cnt == 3'h0) begin
            sda_oe_n <= rd_byte[7];
            sh       <= {rd_byte[6:0], 1'b0};
          end else begin
            sda_oe_n <= sh[7];
            sh       <= {sh[6:0], 1'b0};
          end
        end
        ST_RD_ACK: sda_oe_n <= 1'b1;
        ST_IDLE, ST_SEL, ST_ADR_HI, ST_ADR_LO, ST_WDATA, ST_WAIT: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // status outputs

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      SELECTED <= 1'b0;
    end else begin
      SELECTED <= state != ST_IDLE;
    end
  end

  assign ADDR_COUNTER      = addr_cnt;
  assign LINK.dev_sda_oe_n = sda_oe_n;
  assign LINK.dev_sda_out  = 1'b0;

endmodule

// File: design/sere_host.sv
// bus master end: runs random, current, id page reads and the lock probe
// assumes software on a plain register port; the master alone drives scl
module sere_host (
  input  wire logic        CORE_CLK,
  input  wire logic        NRST,
  sere_link_if.host        LINK,
  input  wire logic [1:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output logic      [31:0] REG_RDATA
);

  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_HOLD, H_STOP} sere_host_state_t;
  typedef enum logic [2:0] {P_DSW, P_AHI, P_ALO, P_PROBE, P_DSR, P_RX, P_END} sere_phase_t;

  sere_host_state_t   hst;
  sere_phase_t        phase;
  sere_pkg::sere_op_t op;
  logic [2:0]  cs;
  logic [7:0]  cnt;
  logic [15:0] addr;
  logic        start_req;
  logic [7:0]  rx_data;
  logic        rx_full;
  logic        rx_stb;
  logic        nack_err;
  logic        locked;
  logic [8:0]  qdiv;
  logic        tick;
  logic [1:0]  q;
  logic [3:0]  bitn;
  logic [7:0]  txsh;
  logic [7:0]  rxsh;
  logic [7:0]  remaining;
  logic        scl;
  logic        sda_oe_n;
  logic [3:0]  dev_type;

  assign dev_type = (op == sere_pkg::OP_IDPAGE || op == sere_pkg::OP_LOCKPROBE)
                    ? sere_pkg::IDPG_TYPE : sere_pkg::ARRAY_TYPE;

  ////////////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      op        <= sere_pkg::OP_RANDOM;
      cs        <= 3'h0;
      cnt       <= 8'h01;
      addr      <= 16'h0000;
      start_req <= 1'b0;
      rx_data   <= 8'h00;
      rx_full   <= 1'b0;
      REG_RDATA <= 32'h00000000;
    end else begin
      if (REG_WR && REG_ADDR == sere_pkg::REG_CMD && hst == H_IDLE && !start_req) begin
        op        <= sere_pkg::sere_op_t'(REG_WDATA[sere_pkg::CMD_OP_LSB +: 2]);
        cs        <= REG_WDATA[sere_pkg::CMD_CS_LSB +: 3];
        cnt       <= REG_WDATA[sere_pkg::CMD_CNT_LSB +: 8];
        start_req <= 1'b1;
      end else if (hst != H_IDLE) begin
        start_req <= 1'b0;
      end
      if (REG_WR && REG_ADDR == sere_pkg::REG_ADDRESS && hst == H_IDLE) begin
        addr <= REG_WDATA[15:0];
      end
      // a new byte wins over a read that clears the flag
      if (rx_stb) begin
        rx_data <= rxsh;
        rx_full <= 1'b1;
      end else if (REG_RD && REG_ADDR == sere_pkg::REG_DATA) begin
        rx_full <= 1'b0;
      end
      REG_RDATA <= 32'h00000000;
      if (REG_RD) begin
        unique case (REG_ADDR)
          sere_pkg::REG_CMD:     REG_RDATA <= {16'h0000, cnt, 3'h0, cs, op};
          sere_pkg::REG_ADDRESS: REG_RDATA <= {16'h0000, addr};
          sere_pkg::REG_DATA:    REG_RDATA <= {24'h000000, rx_data};
          sere_pkg::REG_STATUS:  REG_RDATA <= {28'h0000000, locked, nack_err, rx_full,
                                              start_req | (hst != H_IDLE)};
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // quarter bit divider

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      qdiv <= 9'h000;
      tick <= 1'b0;
    end else begin
      tick <= qdiv == sere_pkg::QUARTER_LAST;
      qdiv <= (qdiv == sere_pkg::QUARTER_LAST) ? 9'h000 : qdiv + 9'h001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // transaction sequencer, one step per quarter bit

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      hst <= H_IDLE;
      phase <= P_DSW;
      q <= 2'h0;
      bitn <= 4'h0;
      txsh <= 8'h00;
      rxsh <= 8'h00;
      remaining <= 8'h00;
      scl <= 1'b1;
      sda_oe_n <= 1'b1;
      nack_err <= 1'b0;
      locked <= 1'b0;
      rx_stb <= 1'b0;
    end else begin
      rx_stb <= 1'b0;
      if (tick) begin
        q <= q + 2'h1;
        unique case (hst)
          H_IDLE: begin
            q <= 2'h0;
            if (start_req) begin
              hst       <= H_START;
              nack_err  <= 1'b0;
              remaining <= (cnt == 8'h00) ? 8'h01 : cnt;
              phase     <= (op == sere_pkg::OP_CURRENT) ? P_DSR : P_DSW;
            end
          end
          // scl low, release, scl high, pull data low: works as first or repeated start
          H_START: begin
            unique case (q)
              2'h0: scl <= 1'b0;
              2'h1: sda_oe_n <= 1'b1;
              2'h2: scl <= 1'b1;
              2'h3: begin
                sda_oe_n <= 1'b0;
                bitn     <= 4'h0;
                hst      <= (phase == P_END) ? H_STOP : H_BIT;
                txsh     <= {dev_type, cs, phase == P_DSR};
              end
            endcase
          end
          H_HOLD: begin
            q <= 2'h0;
            if (!rx_full && !rx_stb) begin
              hst <= H_BIT;
            end
          end
          H_BIT: begin
            unique case (q)
              2'h0: scl <= 1'b0;
              2'h1: begin
                if (phase == P_RX) begin
                  // last wanted byte is left unacknowledged
                  sda_oe_n <= (bitn == 4'h8) ? (remaining == 8'h01) : 1'b1;
                end else begin
                  sda_oe_n <= (bitn == 4'h8) ? 1'b1 : txsh[7];
                end
              end
              2'h2: scl <= 1'b1;
              2'h3: begin
                if (bitn != 4'h8) begin
                  txsh <= {txsh[6:0], 1'b0};
                  rxsh <= {rxsh[6:0], LINK.sda};
                  bitn <= bitn + 4'h1;
                  if (phase == P_RX && bitn == 4'h7) begin
                    rx_stb <= 1'b1;
                    hst    <= H_HOLD;
                  end
                end else begin
                  bitn <= 4'h0;
                  unique case (phase)
                    P_DSW, P_AHI, P_ALO, P_DSR: begin
                      if (LINK.sda) begin
                        nack_err <= 1'b1;
                        hst      <= H_STOP;
                      end else if (phase == P_DSW) begin
                        phase <= P_AHI;
                        txsh  <= addr[15:8];
                      end else if (phase == P_AHI) begin
                        phase <= P_ALO;
                        txsh  <= addr[7:0];
                      end else if (phase == P_ALO && op == sere_pkg::OP_LOCKPROBE) begin
                        phase <= P_PROBE;
                        txsh  <= sere_pkg::PROBE_DATA;
                      end else if (phase == P_ALO) begin
                        phase <= P_DSR;
                        hst   <= H_START;
                      end else begin
                        phase <= P_RX;
                      end
                    end
                    P_PROBE: begin
                      locked <= LINK.sda;
                      phase  <= P_END;
                      hst    <= H_START;
                    end
                    P_RX: begin
                      remaining <= remaining - 8'h01;
                      if (remaining == 8'h01) begin
                        hst <= H_STOP;
                      end
                    end
                    P_END: hst <= H_STOP;
                  endcase
                end
              end
            endcase
          end
          H_STOP: begin
            unique case (q)
              2'h0: scl <= 1'b0;
              2'h1: sda_oe_n <= 1'b0;
              2'h2: scl <= 1'b1;
              2'h3: begin
                sda_oe_n <= 1'b1;
                hst      <= H_IDLE;
              end
            endcase
          end
        endcase
      end
    end
  end

  assign LINK.scl           = scl;
  assign LINK.host_sda_oe_n = sda_oe_n;
  assign LINK.host_sda_out  = 1'b0;

endmodule

// File: verif/sere_link_properties.sv
// link checker for the eeprom read engine and its bus master
// assumes it sits beside the link interface, on the core clock and reset
module sere_link_properties (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic scl,
  input wire logic host_sda_out,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic sda
);
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bit_idx;
  logic       first_byte;
  logic       nacked;
  logic       rise;
  logic       start_seen;
  logic       stop_seen;

  assign rise       = scl & ~scl_q;
  assign start_seen = scl & scl_q & sda_q & ~sda;
  assign stop_seen  = scl & scl_q & ~sda_q & sda;

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // rises counted per byte, restarted by every start, so bit 9 is the ack slot
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      bit_idx <= 4'h0;
    end else if (start_seen) begin
      bit_idx <= 4'h0;
    end else if (rise) begin
      bit_idx <= (bit_idx == 4'h9) ? 4'h1 : bit_idx + 4'h1;
    end
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      first_byte <= 1'b0;
      nacked     <= 1'b0;
    end else if (start_seen) begin
      first_byte <= 1'b1;
      nacked     <= 1'b0;
    end else if (rise && bit_idx == 4'h8) begin
      first_byte <= 1'b0;
      nacked     <= nacked | sda;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!NRST);

  start_release_a : assert property (start_seen |-> dev_sda_oe_n [*8])
    else $error("device pulls data just after a start");
  stop_standby_a : assert property (stop_seen |-> dev_sda_oe_n [*8])
    else $error("device pulls data just after a stop");
  steady_high_a : assert property (scl && scl_q |-> $stable(dev_sda_oe_n))
    else $error("device data changed while clock high");
  change_after_fall_a : assert property ($changed(dev_sda_oe_n) |->
    !scl && !$past(scl) && ($past(scl, 2) || $past(scl, 3)))
    else $error("device data changed away from a clock fall");
  no_contention_a : assert property (rise |-> host_sda_oe_n || dev_sda_oe_n)
    else $error("both ends pull data at a clock rise");
  select_listen_a : assert property (rise && first_byte && bit_idx < 4'h8 |-> dev_sda_oe_n)
    else $error("device pulls data during select bits");
  nack_standby_a : assert property (nacked |-> dev_sda_oe_n)
    else $error("device drives after a missing ack");
  pull_value_a : assert property (!host_sda_out && !dev_sda_out)
    else $error("data pull value is not low");
endmodule

// File: verif/serial_eeprom_read_engine_tb_top.sv
// bench joining host and eeprom ends over the link; reads checked via the register port
// assumes the design package, interface and both ends are compiled first
`define CHECK(what, exp, got) begin \
  comparisons++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("wrong value %s expected %0h seen %0h", what, (exp), (got)); \
  end \
end

module serial_eeprom_read_engine_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk;
  logic        nrst;
  logic [1:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        wp;
  logic [2:0]  cs;
  logic        id_locked;
  logic        wr_en;
  logic        wr_id;
  logic [13:0] wr_addr;
  logic [7:0]  wr_data;
  logic [13:0] addr_counter;
  logic        selected;
  logic        data_pend;
  logic [7:0]  expq[$];
  logic [7:0]  expv;
  logic [7:0]  b0;
  logic [7:0]  b1;
  logic [31:0] st;
  int          failures;
  int          comparisons;
  int          cycles;
  integer      seed;

  sere_link_if sere_link_if_i ();
  sere_host sere_host_i (.CORE_CLK(core_clk), .NRST(nrst), .LINK(sere_link_if_i),
    .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_RDATA(reg_rdata));
  sere_device #(.WAFER_FORM(1'b1)) sere_device_i (.CORE_CLK(core_clk), .NRST(nrst),
    .LINK(sere_link_if_i),
    .WRITE_PROTECT_INPUT(wp), .CHIP_SELECT_PIN_HIGH(cs[2]), .CHIP_SELECT_PIN_MID(cs[1]),
    .CHIP_SELECT_PIN_LOW(cs[0]), .ID_LOCKED(id_locked), .WR_EN(wr_en), .WR_ID_PAGE(wr_id),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data), .ADDR_COUNTER(addr_counter), .SELECTED(selected));
  sere_link_properties sere_link_properties_i (.CORE_CLK(core_clk), .NRST(nrst),
    .scl(sere_link_if_i.scl), .host_sda_out(sere_link_if_i.host_sda_out),
    .host_sda_oe_n(sere_link_if_i.host_sda_oe_n), .dev_sda_out(sere_link_if_i.dev_sda_out),
    .dev_sda_oe_n(sere_link_if_i.dev_sda_oe_n), .sda(sere_link_if_i.sda));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // every task leaves a spare edge so no strobe is set twice in one step
  task automatic reg_write(input logic [1:0] a, input logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic reg_read(input logic [1:0] a, output logic [31:0] d);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(posedge core_clk);
    d = reg_rdata;
  endtask

  task automatic mem_write(input logic id, input logic [13:0] a, input logic [7:0] d);
    wr_id   <= id;
    wr_addr <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge core_clk);
    wr_en <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic poll(input int pos, input logic lvl, output logic [31:0] st);
    for (int n = 0; n < 40000; n++) begin
      reg_read(sere_pkg::REG_STATUS, st);
      if (st[pos] === lvl) break;
    end
  endtask

  task automatic do_read(input sere_pkg::sere_op_t op, input logic [7:0] want[$]);
    logic [31:0] st;
    reg_write(sere_pkg::REG_CMD, {16'h0000, 8'(want.size()), 3'h0, cs, op});
    foreach (want[i]) begin
      poll(sere_pkg::ST_RXFULL, 1'b1, st);
      expq.push_back(want[i]);
      reg_read(sere_pkg::REG_DATA, st);
    end
    poll(sere_pkg::ST_BUSY, 1'b0, st);
    `CHECK("nack flag", 1'b0, st[sere_pkg::ST_NACKERR])
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // read data stand only in the cycle after the strobe, so compare there
  always @(posedge core_clk) begin
    cycles++;
    if (data_pend) begin
      expv = expq.pop_front();
      `CHECK("read byte", expv, reg_rdata[7:0])
    end
    data_pend = reg_rd && reg_addr === sere_pkg::REG_DATA;
    if (cycles > 80000) begin
      failures++;
      end_of_test();
    end
  end

  initial begin
    seed = 32'hBED769AA;
    nrst = 1'b0;
    data_pend = 1'b0;
    {reg_wr, reg_rd, wr_en, wr_id, reg_addr, reg_wdata, wr_addr, wr_data} = '0;
    {id_locked, wp, cs} = 5'($random(seed));
    {b0, b1} = 16'($random(seed));
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    `CHECK("selected after reset", 1'b0, selected)
    // last array byte left unwritten so the wafer pattern still shows
    mem_write(1'b0, 14'h0000, b1);
    // top two address bits set on purpose: the counter must drop them
    reg_write(sere_pkg::REG_ADDRESS, 32'h0000FFFF);
    do_read(sere_pkg::OP_RANDOM, '{sere_pkg::WAFER_LAST, b1});
    `CHECK("counter after wrap", 14'h0001, addr_counter)
    `CHECK("standby after stop", 1'b0, selected)
    wp <= ~wp;
    do_read(sere_pkg::OP_CURRENT, '{sere_pkg::ERASED});
    `CHECK("counter after current", 14'h0002, addr_counter)
    mem_write(1'b1, 14'h0005, b0);
    mem_write(1'b0, 14'h0006, b1);
    // upper byte and top two low bits are noise the id page must ignore
    reg_write(sere_pkg::REG_ADDRESS, 32'h0000A6C5);
    do_read(sere_pkg::OP_IDPAGE, '{b0});
    `CHECK("counter after id page", 14'h0006, addr_counter)
    do_read(sere_pkg::OP_CURRENT, '{b1});
    reg_write(sere_pkg::REG_CMD, {16'h0000, 8'h01, 3'h0, cs, sere_pkg::OP_LOCKPROBE});
    poll(sere_pkg::ST_BUSY, 1'b0, st);
    `CHECK("lock status", id_locked, st[sere_pkg::ST_LOCKED])
    `CHECK("probe nack flag", 1'b0, st[sere_pkg::ST_NACKERR])
    end_of_test();
  end
endmodule
